/* src/test_simd_alu_pkg.sv */
// Shared constants, register map and carriers for the test and unsigned SIMD datapath
package test_simd_alu_pkg;

  localparam int DATA_W    = 32;
  localparam int REG_IDX_W = 4;
  localparam int OP_W      = 3;
  localparam int DEC_W     = 8;

  // Register byte offsets
  localparam logic [DEC_W-1:0] OPERAND_A_OFFSET = 8'h00;
  localparam logic [DEC_W-1:0] OPERAND_B_OFFSET = 8'h04;
  localparam logic [DEC_W-1:0] COMMAND_OFFSET   = 8'h08;
  localparam logic [DEC_W-1:0] RESULT_OFFSET    = 8'h0c;
  localparam logic [DEC_W-1:0] FLAGS_OFFSET     = 8'h10;
  localparam logic [DEC_W-1:0] STATUS_OFFSET    = 8'h14;

  // Command register fields
  localparam int CMD_OP_LSB       = 0;
  localparam int CMD_COND_BIT     = 4;
  localparam int CMD_SHIFTED_BIT  = 5;
  localparam int CMD_CARRY_BIT    = 6;
  localparam int CMD_OMITTED_BIT  = 7;
  localparam int CMD_DEST_LSB     = 8;
  localparam int CMD_FIRST_LSB    = 12;

  // Flags register fields
  localparam int FLAG_N_BIT = 31;
  localparam int FLAG_Z_BIT = 30;
  localparam int FLAG_C_BIT = 29;
  localparam int FLAG_V_BIT = 28;

  // Status register fields
  localparam int STAT_WROTE_BIT   = 0;
  localparam int STAT_SKIPPED_BIT = 1;
  localparam int STAT_FLAGS_BIT   = 2;
  localparam int STAT_DEST_LSB    = 4;
  localparam int STAT_COUNT_LSB   = 16;
  localparam int COUNT_W          = 16;

  // Reset values
  localparam logic [DATA_W-1:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [3:0]        FLAGS_RESET = 4'h0;

  // Operation codes
  localparam logic [OP_W-1:0] BIT_TEST_OP              = 3'h0;
  localparam logic [OP_W-1:0] EQUIVALENCE_TEST_OP      = 3'h1;
  localparam logic [OP_W-1:0] PACKED_HALFWORD_ADD_OP   = 3'h2;
  localparam logic [OP_W-1:0] PACKED_BYTE_ADD_OP       = 3'h3;
  localparam logic [OP_W-1:0] EXCHANGE_ADD_SUBTRACT_OP = 3'h4;
  localparam logic [OP_W-1:0] EXCHANGE_SUBTRACT_ADD_OP = 3'h5;
  localparam logic [OP_W-1:0] HALVING_HALFWORD_ADD_OP  = 3'h6;
  localparam logic [OP_W-1:0] HALVING_BYTE_ADD_OP      = 3'h7;

  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic       HRESP_OKAY  = 1'h0;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } status_flags_s;

  typedef struct packed {
    logic                 valid;
    logic [REG_IDX_W-1:0] dest;
    logic [DATA_W-1:0]    data;
  } writeback_s;

  typedef struct packed {
    logic [REG_IDX_W-1:0] first;
    logic [REG_IDX_W-1:0] dest;
    logic                 omitted;
    logic                 carry;
    logic                 shifted;
    logic                 cond_pass;
    logic [OP_W-1:0]      op;
  } command_s;

endpackage

/* src/test_simd_alu.sv */
// Test and unsigned packed SIMD datapath slice with an AHB-Lite register slave
// Contract
// - Bit test ANDs operands, flags only
// - Equivalence test XORs operands, flags only
// - Tests set N from bit 31, Z
// - Tests load C from shifter when shifted
// - Tests never change overflow flag
// - Equivalence N equals XOR of signs
// - Failed condition writes nothing, keeps flags
// - Halfword add: two independent 16-bit sums
// - Byte add: four independent 8-bit sums
// - Packed and halving adds keep flags
// - Add-subtract bottom: a.lo minus b.hi
// - Add-subtract top: a.hi plus b.lo
// - Subtract-add bottom: a.lo plus b.hi
// - Subtract-add top: a.hi minus b.lo
// - Exchange operations keep condition flags
// - Halving halfword add halves each sum
// - Halving byte add halves each sum
// - Omitted destination writes first-operand register
`timescale 1ns/1ps

module test_simd_alu
  import test_simd_alu_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic                 hready,
  input  wire logic [DATA_W-1:0]    hwdata,
  output logic      [DATA_W-1:0]    hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  output status_flags_s             program_status_flags,
  output writeback_s                writeback
);

  // Lane add on halfwords or bytes; each lane sum is one bit wider than the lane
  function automatic logic [DATA_W-1:0] lane_add(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b,
    input logic              byte_lanes,
    input logic              halve
  );
    logic [16:0]       sum16;
    logic [8:0]        sum8;
    logic [DATA_W-1:0] r;
    r = WORD_RESET;
    if (byte_lanes)
    begin
      for (int i = 0; i < 4; i++)
      begin
        sum8 = {1'b0, a[8*i +: 8]} + {1'b0, b[8*i +: 8]};
        r[8*i +: 8] = halve ? sum8[8:1] : sum8[7:0];
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        sum16 = {1'b0, a[16*i +: 16]} + {1'b0, b[16*i +: 16]};
        r[16*i +: 16] = halve ? sum16[16:1] : sum16[15:0];
      end
    end
    return r;
  endfunction

  logic [DATA_W-1:0] operand_a;
  logic [DATA_W-1:0] operand_b;
  command_s          command;
  logic [DATA_W-1:0] result;
  logic              exec_pending;
  logic              last_wrote;
  logic              last_skipped;
  logic              last_flags;
  logic [COUNT_W-1:0] exec_count;

  logic              wr_pending;
  logic [DEC_W-1:0]  wr_addr;
  logic              rd_pending;
  logic [DEC_W-1:0]  rd_addr;
  logic              bus_take;

  logic [DATA_W-1:0] calc_value;
  logic              calc_is_test;
  logic              calc_n;
  logic              calc_z;
  logic              calc_c;
  logic [DATA_W-1:0] read_mux;
  logic [REG_IDX_W-1:0] next_dest;

  // Only whole-word single transfers are issued, so hsize needs no decode
  assign bus_take = hsel & hready & htrans[1];

  // Address phase capture; reads take one wait state so prior writes have landed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending <= 1'b0;
      wr_addr    <= '0;
      rd_pending <= 1'b0;
      rd_addr    <= '0;
    end
    else
    begin
      wr_pending <= bus_take & hwrite;
      rd_pending <= bus_take & ~hwrite;
      if (bus_take)
      begin
        wr_addr <= haddr[DEC_W-1:0];
        rd_addr <= haddr[DEC_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
    else
    begin
      hresp <= HRESP_OKAY;
      if (bus_take & ~hwrite)
        hreadyout <= 1'b0;
      else
        hreadyout <= 1'b1;
    end
  end

  always_comb
  begin
    read_mux = WORD_RESET;
    case (rd_addr)
      OPERAND_A_OFFSET: read_mux = operand_a;
      OPERAND_B_OFFSET: read_mux = operand_b;
      // Fields sit at their word positions; bits between them read as zero
      COMMAND_OFFSET:
      begin
        read_mux[CMD_OP_LSB +: OP_W]         = command.op;
        read_mux[CMD_COND_BIT]               = command.cond_pass;
        read_mux[CMD_SHIFTED_BIT]            = command.shifted;
        read_mux[CMD_CARRY_BIT]              = command.carry;
        read_mux[CMD_OMITTED_BIT]            = command.omitted;
        read_mux[CMD_DEST_LSB +: REG_IDX_W]  = command.dest;
        read_mux[CMD_FIRST_LSB +: REG_IDX_W] = command.first;
      end
      RESULT_OFFSET:    read_mux = result;
      FLAGS_OFFSET:
      begin
        read_mux[FLAG_N_BIT] = program_status_flags.n;
        read_mux[FLAG_Z_BIT] = program_status_flags.z;
        read_mux[FLAG_C_BIT] = program_status_flags.c;
        read_mux[FLAG_V_BIT] = program_status_flags.v;
      end
      STATUS_OFFSET:
      begin
        read_mux[STAT_WROTE_BIT]                      = last_wrote;
        read_mux[STAT_SKIPPED_BIT]                    = last_skipped;
        read_mux[STAT_FLAGS_BIT]                      = last_flags;
        read_mux[STAT_DEST_LSB +: REG_IDX_W]          = writeback.dest;
        read_mux[STAT_COUNT_LSB +: COUNT_W]           = exec_count;
      end
      default:          read_mux = WORD_RESET;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= WORD_RESET;
    else if (rd_pending)
      hrdata <= read_mux;
  end

  // Operand and command registers; a command write launches one operation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      operand_a    <= WORD_RESET;
      operand_b    <= WORD_RESET;
      command      <= '0;
      exec_pending <= 1'b0;
    end
    else
    begin
      exec_pending <= wr_pending && (wr_addr == COMMAND_OFFSET);
      if (wr_pending)
      begin
        case (wr_addr)
          OPERAND_A_OFFSET: operand_a <= hwdata;
          OPERAND_B_OFFSET: operand_b <= hwdata;
          // The carrier is packed tighter than the word, so pick fields by position
          COMMAND_OFFSET:
          begin
            command.op        <= hwdata[CMD_OP_LSB +: OP_W];
            command.cond_pass <= hwdata[CMD_COND_BIT];
            command.shifted   <= hwdata[CMD_SHIFTED_BIT];
            command.carry     <= hwdata[CMD_CARRY_BIT];
            command.omitted   <= hwdata[CMD_OMITTED_BIT];
            command.dest      <= hwdata[CMD_DEST_LSB +: REG_IDX_W];
            command.first     <= hwdata[CMD_FIRST_LSB +: REG_IDX_W];
          end
          default:          ;
        endcase
      end
    end
  end

  // Datapath for the selected operation
  always_comb
  begin
    calc_value   = WORD_RESET;
    calc_is_test = 1'b0;
    case (command.op)
      BIT_TEST_OP:
      begin
        calc_value   = operand_a & operand_b;
        calc_is_test = 1'b1;
      end
      EQUIVALENCE_TEST_OP:
      begin
        calc_value   = operand_a ^ operand_b;
        calc_is_test = 1'b1;
      end
      PACKED_HALFWORD_ADD_OP:  calc_value = lane_add(operand_a, operand_b, 1'b0, 1'b0);
      PACKED_BYTE_ADD_OP:      calc_value = lane_add(operand_a, operand_b, 1'b1, 1'b0);
      EXCHANGE_ADD_SUBTRACT_OP:
      begin
        calc_value[15:0]  = operand_a[15:0] - operand_b[31:16];
        calc_value[31:16] = operand_a[31:16] + operand_b[15:0];
      end
      EXCHANGE_SUBTRACT_ADD_OP:
      begin
        calc_value[15:0]  = operand_a[15:0] + operand_b[31:16];
        calc_value[31:16] = operand_a[31:16] - operand_b[15:0];
      end
      HALVING_HALFWORD_ADD_OP: calc_value = lane_add(operand_a, operand_b, 1'b0, 1'b1);
      HALVING_BYTE_ADD_OP:     calc_value = lane_add(operand_a, operand_b, 1'b1, 1'b1);
      default:                 calc_value = WORD_RESET;
    endcase
  end

  assign calc_n = calc_value[DATA_W-1];
  assign calc_z = (calc_value == WORD_RESET);
  assign calc_c = command.shifted ? command.carry : program_status_flags.c;

  assign next_dest = command.omitted ? command.first : command.dest;

  // Flags; a launched test overrides a same-cycle software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      program_status_flags <= FLAGS_RESET;
    else if (exec_pending && command.cond_pass && calc_is_test)
    begin
      program_status_flags.n <= calc_n;
      program_status_flags.z <= calc_z;
      program_status_flags.c <= calc_c;
      program_status_flags.v <= program_status_flags.v;
    end
    else if (wr_pending && (wr_addr == FLAGS_OFFSET))
    begin
      program_status_flags.n <= hwdata[FLAG_N_BIT];
      program_status_flags.z <= hwdata[FLAG_Z_BIT];
      program_status_flags.c <= hwdata[FLAG_C_BIT];
      program_status_flags.v <= hwdata[FLAG_V_BIT];
    end
  end

  // Writeback port: one-cycle pulse, destination and data held afterwards
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      writeback <= '0;
      result    <= WORD_RESET;
    end
    else
    begin
      writeback.valid <= 1'b0;
      if (exec_pending && command.cond_pass && !calc_is_test)
      begin
        writeback.valid <= 1'b1;
        writeback.dest  <= next_dest;
        writeback.data  <= calc_value;
        // Software reads back the last written value, tests leave it alone
        result          <= calc_value;
      end
    end
  end

  // Outcome of the most recent launch, for software to inspect
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_wrote   <= 1'b0;
      last_skipped <= 1'b0;
      last_flags   <= 1'b0;
      exec_count   <= '0;
    end
    else if (exec_pending)
    begin
      last_wrote   <= command.cond_pass & ~calc_is_test;
      last_skipped <= ~command.cond_pass;
      last_flags   <= command.cond_pass & calc_is_test;
      exec_count   <= exec_count + 1'b1;
    end
  end

endmodule // test_simd_alu

/* testbench/simd_alu_checker.sv */
// Concurrent checks on the datapath's bus and result ports
`timescale 1ns/1ps

module simd_alu_checker
  import test_simd_alu_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [DATA_W-1:0] hwdata,
  input wire status_flags_s     program_status_flags,
  input wire writeback_s        writeback
);
  logic       wr_q;
  logic [7:0] wa_q;
  logic       cmd;
  logic       test;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Write data phases, so a command is seen with its data
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end
    else if (hready)
    begin
      wr_q <= hsel && htrans[1] && hwrite;
      wa_q <= haddr[7:0];
    end

  assign cmd  = wr_q && wa_q == COMMAND_OFFSET;
  assign test = hwdata[2:0] < 3'h2;

  chk_test_no_wb: assert property (cmd && test |-> ##2 !writeback.valid)
    else $error("Test operation produced a writeback");
  chk_test_nz: assert property (cmd && test && hwdata[4] |->
    ##2 !(program_status_flags.n && program_status_flags.z))
    else $error("Negative and zero both set after a test");
  chk_c_kept: assert property (cmd && test && !hwdata[5] |->
    ##2 $stable(program_status_flags.c))
    else $error("Carry changed without a shifted operand");
  chk_c_load: assert property (cmd && test && hwdata[4] && hwdata[5] |->
    ##2 program_status_flags.c == $past(hwdata[6], 2))
    else $error("Carry not loaded from shifter carry");
  chk_v_kept: assert property (cmd && test |-> ##2 $stable(program_status_flags.v))
    else $error("Overflow changed by a test");
  chk_skip_quiet: assert property (cmd && !hwdata[4] |->
    ##2 !writeback.valid && $stable(program_status_flags))
    else $error("Failed condition still had an effect");
  chk_add_wb: assert property (cmd && hwdata[4] && !test |->
    ##2 writeback.valid && $stable(program_status_flags))
    else $error("Packed operation writeback or flags wrong");
  chk_omit_dest: assert property (cmd && hwdata[4] && !test && hwdata[7] |->
    ##2 writeback.dest == $past(hwdata[15:12], 2))
    else $error("Omitted destination not the first register");
  chk_wb_pulse: assert property (writeback.valid |=> !writeback.valid)
    else $error("Writeback valid longer than one cycle");

  chk_resp_okay: assert property (hresp == HRESP_OKAY)
    else $error("Slave response not OKAY");
  chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
    !hreadyout ##1 hreadyout)
    else $error("Read wait state not exactly one cycle");

  cover property (cmd && test && hwdata[4] && hwdata[5]);
  cover property (cmd && !hwdata[4]);
  cover property (cmd && hwdata[4] && hwdata[7] && !test);
endmodule // simd_alu_checker

/* testbench/bus_master.sv */
// AHB-Lite master model standing in for the decoder side
`timescale 1ns/1ps

module bus_master
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [31:0]      hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  // One single word transfer; read data taken at the closing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    // Reads invert the data lines, so a second read in a row restores the last write value
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule // bus_master

/* testbench/test_and_unsigned_simd_alu_bench.sv */
// Self-checking bench for the test and packed SIMD datapath
`timescale 1ns/1ps

module test_and_unsigned_simd_alu_bench;
  import test_simd_alu_pkg::*;
  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic          hreadyout;
  status_flags_s flags_o;
  writeback_s    wb;
  status_flags_s fl;
  logic [35:0]   q[$];
  logic [31:0]   rd;
  logic [31:0]   discard;
  logic [31:0]   res_exp = 32'h0;
  logic [3:0]    dest_exp = 4'h0;
  logic [15:0]   launches = 16'h0;
  int            bad_count = 0;
  int            compares = 0;
  int            cyc = 0;
  int            i;

  always #25 hclk = ~hclk;

  bus_master m_u (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
                  .hwdata);
  test_simd_alu dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
                       .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp(),
                       .program_status_flags(flags_o), .writeback(wb));

  task automatic chk(input logic [35:0] e, input logic [35:0] s, input string nm);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] calc(input logic [2:0] op, input logic [31:0] a, b);
    logic [31:0] r;
    logic [16:0] s;
    logic [8:0]  t;
    r = (op == 3'h0) ? (a & b) : (a ^ b);
    if (op == 3'h4)
      r = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
    if (op == 3'h5)
      r = {a[31:16] - b[15:0], a[15:0] + b[31:16]};
    for (int k = 0; k < 2; k++)
    begin
      s = a[k*16+:16] + b[k*16+:16];
      if (op == 3'h2 || op == 3'h6)
        r[k*16+:16] = (op == 3'h6) ? s[16:1] : s[15:0];
    end
    for (int k = 0; k < 4; k++)
    begin
      t = a[k*8+:8] + b[k*8+:8];
      if (op == 3'h3 || op == 3'h7)
        r[k*8+:8] = (op == 3'h7) ? t[8:1] : t[7:0];
    end
    return r;
  endfunction

  task automatic run(input logic [2:0] op, input logic [31:0] a, b, input logic [3:0] ctl);
    logic [3:0]  d;
    logic [3:0]  f;
    logic [31:0] r;
    logic [31:0] x;
    logic [31:0] c;
    // indices stay clear of stack and program counter
    d = 4'($urandom % 13);
    f = 4'($urandom % 13);
    r = calc(op, a, b);
    m_u.xfer(1'b1, OPERAND_A_OFFSET, a, x);
    m_u.xfer(1'b1, OPERAND_B_OFFSET, b, x);
    if (ctl[0] && op > 3'h1)
      q.push_back({ctl[3] ? f : d, r});
    if (ctl[0] && op < 3'h2)
    begin
      fl.n = r[31];
      fl.z = (r == 32'h0);
      fl.c = ctl[1] ? ctl[2] : fl.c;
    end
    c = {16'h0, f, d, ctl, 1'b0, op};
    launches++;
    if (ctl[0] && op > 3'h1)
    begin
      res_exp  = r;
      dest_exp = ctl[3] ? f : d;
    end
    m_u.xfer(1'b1, COMMAND_OFFSET, c, x);
    m_u.xfer(1'b0, FLAGS_OFFSET, 32'h0, x);
    chk(36'(fl), 36'(x[31:28]), "flags");
    m_u.xfer(1'b0, COMMAND_OFFSET, 32'h0, x);
    chk(36'(c), 36'(x), "command readback");
    m_u.xfer(1'b0, RESULT_OFFSET, 32'h0, x);
    chk(36'(res_exp), 36'(x), "result");
    m_u.xfer(1'b0, STATUS_OFFSET, 32'h0, x);
    c = {launches, 8'h0, dest_exp, 1'b0, ctl[0] && op < 3'h2, !ctl[0], ctl[0] && op > 3'h1};
    chk(36'(c), 36'(x), "status");
  endtask

  always @(posedge hclk)
    if (wb.valid === 1'b1)
    begin
      if (q.size() == 0)
        chk(36'h0, 36'h1, "unexpected writeback");
      else
        chk(q.pop_front(), {wb.dest, wb.data}, "writeback");
    end

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done;
    end
  end

  initial
  begin
    void'($urandom(32'h4982));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    fl = FLAGS_RESET;
    m_u.xfer(1'b0, FLAGS_OFFSET, 32'h0, rd);
    chk(36'h0, 36'(rd), "flags reset");
    m_u.xfer(1'b0, 8'h20, 32'h0, rd);
    chk(36'h0, 36'(rd), "unmapped");
    // Lane edges: carries that must not cross and halving carries kept
    for (i = 0; i < 8; i++)
      run(i[2:0], 32'hff80_ffff, 32'h0181_0001, 4'h3);
    for (i = 0; i < 120; i++)
    begin
      rd = $urandom;
      m_u.xfer(1'b1, FLAGS_OFFSET, rd, discard);
      fl = rd[31:28];
      run(3'($urandom % 8), $urandom, $urandom, 4'($urandom));
    end
    repeat (4) @(posedge hclk);
    chk(36'h0, 36'(q.size()), "pending writebacks");
    test_done;
  end
endmodule // test_and_unsigned_simd_alu_bench

bind test_simd_alu simd_alu_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hwdata, .program_status_flags, .writeback);
